// ---- rtl/dti_top.sv ----
// Behaviour
// (R1) mode 3: input3 enable, input1 run, input2 direction
// (R2) enabled run press starts; direction inactive forward
// (R3) enable inactive stops at once
// (R4) run acts on its on edge
// (R5) up/down ramp at set rate, thousandths
// (R6) resolution 1 scales rate by ten
// (R7) separate on and off delays per input
// (R8) delays only on inputs one to five
// (R9) polarity from digits of two settings
// (R10) digit 0: active when open from common
// (R11) digit 1: active when tied to common
// (R12) mux terminal: 0 pulse, 1 switch
// (R13) pulse output never above 50 kHz
// (R14) nine outputs with own function selector
// (R15) function 0 off, function 1 ready
// (R16) function 2 on while running
// (R17) functions 3 and 4 fault stop variants
// (R18) function 5 swing frequency limited
// (R19) function 6 torque limited stall
// (R20) function 7 upper limit reached
// (R21) function 8 lower limit, off stopped
// (R22) function 9 lower limit, on stopped
// (R23) delays count 0.1 s ticks, restart
// (R24) inputs synchronised before use
`include "dti_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dti_top #(
   parameter int DELAY_TICK_CYCLES = `DTI_DELAY_TICK_NS / `DTI_CLK_NS,
   parameter int RAMP_TICK_CYCLES  = `DTI_RAMP_TICK_NS / `DTI_CLK_NS
) (
   input  wire logic        aclk,           // core clock
   input  wire logic        aresetn,        // sync reset
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // byte enables
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready,   // read ready
   input  wire logic [9:0]  term_in,        // 1 = tied to input_common
   input  wire logic        drive_ready,    // circuits stable
   input  wire logic        drive_fault,    // stopped by fault
   input  wire logic        drive_undervolt, // under-voltage
   input  wire logic        drive_running,  // running
   input  wire logic        set_beyond_lim, // set freq outside limits
   input  wire logic        at_upper_lim,   // output at upper limit
   input  wire logic        at_lower_lim,   // output at lower limit
   input  wire logic        speed_ctrl,     // speed control mode
   input  wire logic        torque_lim,     // torque at limit
   output logic [9:0]       input_active,   // conditioned inputs
   output logic             run_cmd,        // run command
   output logic             reverse_cmd,    // reverse direction
   output logic [31:0]      freq_ref_uhz,   // reference, micro-Hz
   output logic [8:0]       term_out        // bit 0 mux terminal
);
   import dti_pkg::*;

   // ---------------- register bus ----------------
   logic [1:0]  cmd_mode_reg;
   logic [15:0] rate_reg;
   logic [1:0]  res_reg;
   logic [19:0] pol_low_reg, pol_high_reg;
   logic        mux_mode_reg;
   logic [15:0] pfreq_reg;
   logic [3:0]  func_reg  [9];
   logic [14:0] delay_reg [10];
   logic [7:0]  awaddr_reg, araddr_reg;
   logic [31:0] wdata_reg, rdata_next;
   logic [3:0]  wstrb_reg;
   logic        aw_full_reg, w_full_reg, rd_ok;
   logic [31:0] wmask, merged;
   logic [1:0]  run_rev_reg;

   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wmask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [5:0] widx = awaddr_reg[7:2];
   wire [5:0] ridx = s_axi_araddr[7:2];
   wire w_func  = widx >= 6'h10 && widx < 6'h19;
   wire w_dly   = widx >= 6'h20 && widx < 6'h2A;
   wire [3:0] wf = 4'(widx - 6'h10);
   wire [3:0] wd = 4'(widx - 6'h20);
   wire [3:0] rf = 4'(ridx - 6'h10);
   wire [3:0] rd = 4'(ridx - 6'h20);
   wire w_known = w_func || w_dly || (widx <= 6'h06);

   function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] msk,
                                       input logic [31:0] nw);
      return (old & ~msk) | (nw & msk);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_known ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign merged = mrg(32'h00000000, wmask, wdata_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_mode_reg <= `DTI_RST_CMD_MODE;
         rate_reg     <= `DTI_RST_UPDN_RATE;
         res_reg      <= `DTI_RST_FREQ_RES;
         pol_low_reg  <= `DTI_RST_POL;
         pol_high_reg <= `DTI_RST_POL;
         mux_mode_reg <= `DTI_RST_MUX_MODE;
         pfreq_reg    <= `DTI_RST_PULSE_FREQ;
         for (int i = 0; i < 9; i++)
            func_reg[i] <= 4'(`DTI_RST_OUT_FUNC >> (4 * i));
         for (int i = 0; i < 10; i++)
            delay_reg[i] <= `DTI_RST_DELAY;
      end else if (do_write) begin
         // a partially strobed write keeps the unstrobed bytes
         if (widx == 6'h00)
            cmd_mode_reg <= 2'(mrg(32'(cmd_mode_reg), wmask, wdata_reg));
         else if (widx == 6'h01)
            rate_reg <= 16'(mrg(32'(rate_reg), wmask, wdata_reg));
         else if (widx == 6'h02)
            res_reg <= 2'(mrg(32'(res_reg), wmask, wdata_reg));
         else if (widx == 6'h03)
            pol_low_reg <= 20'(mrg(32'(pol_low_reg), wmask, wdata_reg));
         else if (widx == 6'h04)
            pol_high_reg <= 20'(mrg(32'(pol_high_reg), wmask, wdata_reg));
         else if (widx == 6'h05)
            mux_mode_reg <= merged[0] | (mux_mode_reg & ~wmask[0]);
         else if (widx == 6'h06)
            pfreq_reg <= 16'(mrg(32'(pfreq_reg), wmask, wdata_reg));
         else if (w_func)
            func_reg[wf] <= 4'(mrg(32'(func_reg[wf]), wmask, wdata_reg));
         else if (w_dly)
            delay_reg[wd] <= 15'(mrg(32'(delay_reg[wd]), wmask, wdata_reg));
      end
   end

   always_comb begin
      rdata_next = 32'h00000000;
      rd_ok = 1'b1;
      if (s_axi_araddr == `DTI_ADDR_CMD_MODE) rdata_next = 32'(cmd_mode_reg);
      else if (s_axi_araddr == `DTI_ADDR_UPDN_RATE) rdata_next = 32'(rate_reg);
      else if (s_axi_araddr == `DTI_ADDR_FREQ_RES) rdata_next = 32'(res_reg);
      else if (s_axi_araddr == `DTI_ADDR_POL_LOW) rdata_next = 32'(pol_low_reg);
      else if (s_axi_araddr == `DTI_ADDR_POL_HIGH) rdata_next = 32'(pol_high_reg);
      else if (s_axi_araddr == `DTI_ADDR_MUX_MODE) rdata_next = 32'(mux_mode_reg);
      else if (s_axi_araddr == `DTI_ADDR_PULSE_FREQ) rdata_next = 32'(pfreq_reg);
      else if (s_axi_araddr == `DTI_ADDR_STATUS) rdata_next = 32'({run_rev_reg, input_active});
      else if (s_axi_araddr == `DTI_ADDR_FREQ_REF) rdata_next = freq_ref_uhz;
      else if (ridx >= 6'h10 && ridx < 6'h19) rdata_next = 32'(func_reg[rf]);
      else if (ridx >= 6'h20 && ridx < 6'h2A) rdata_next = 32'(delay_reg[rd]);
      else rd_ok = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_next;
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- input conditioning ----------------
   logic [9:0] s1_reg, s2_reg, s3_reg, stab_reg, pol_bits, pc;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg   <= 10'h000;
         s2_reg   <= 10'h000;
         s3_reg   <= 10'h000;
         stab_reg <= 10'h000;
      end else begin
         s1_reg   <= term_in;                                      // [R24]
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         stab_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stab_reg);
      end
   end

   // only the low bit of each digit matters; even digits act as 0, odd digits as 1
   assign pol_bits = {pol_high_reg[16], pol_high_reg[12], pol_high_reg[8],
                      pol_high_reg[4], pol_high_reg[0], pol_low_reg[16],
                      pol_low_reg[12], pol_low_reg[8], pol_low_reg[4],
                      pol_low_reg[0]};                             // [R9]
   assign pc = ~(stab_reg ^ pol_bits);                             // [R10] [R11]

   logic [21:0] dtick_cnt_reg;
   wire dtick = dtick_cnt_reg == 22'(DELAY_TICK_CYCLES - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn || dtick) dtick_cnt_reg <= 22'h000000;
      else dtick_cnt_reg <= dtick_cnt_reg + 22'h000001;           // [R23]
   end

   for (genvar g = 0; g < 10; g++) begin : g_in
      logic        act_reg;
      logic [14:0] cnt_reg;
      if (g < 5) begin : g_dly
         wire [14:0] dly = pc[g] ? delay_reg[2*g] : delay_reg[2*g+1];   // [R7]
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               act_reg <= 1'b0;
               cnt_reg <= 15'h0000;
            end else if (pc[g] == act_reg) begin
               cnt_reg <= 15'h0000;                               // [R23]
            end else if (dly == 15'h0000 || (dtick && cnt_reg + 15'h0001 >= dly)) begin
               act_reg <= pc[g];                                  // [R7]
               cnt_reg <= 15'h0000;
            end else if (dtick) begin
               cnt_reg <= cnt_reg + 15'h0001;
            end
         end
      end else begin : g_nodly
         always_ff @(posedge aclk) begin
            if (!aresetn) act_reg <= 1'b0;
            else act_reg <= pc[g];                                // [R8]
            cnt_reg <= 15'h0000;
         end
      end
      assign input_active[g] = act_reg;
   end

   // ---------------- terminal command decode ----------------
   logic p1_reg, p2_reg, run_next, rev_next;
   wire i1 = input_active[0];
   wire i2 = input_active[1];
   wire i3 = input_active[2];
   always_comb begin
      run_next = run_cmd;
      rev_next = reverse_cmd;
      case (dti_cmd_mode_t'(cmd_mode_reg))
         DTI_TWO_LINE_1: begin
            run_next = i1 ^ i2;
            rev_next = i2 & ~i1;
         end
         DTI_TWO_LINE_2: begin
            run_next = i1;
            rev_next = i2;
         end
         DTI_THREE_LINE_1: begin
            if (!i3) run_next = 1'b0;
            else if (i1 && !p1_reg) begin
               run_next = 1'b1;
               rev_next = 1'b0;
            end else if (i2 && !p2_reg) begin
               run_next = 1'b1;
               rev_next = 1'b1;
            end
         end
         DTI_THREE_LINE_2: begin                                  // [R1]
            if (!i3) run_next = 1'b0;                             // [R3]
            else if (i1 && !p1_reg) run_next = 1'b1;              // [R2] [R4]
            rev_next = i2;                                        // [R2]
         end
         default: run_next = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p1_reg      <= 1'b0;
         p2_reg      <= 1'b0;
         run_cmd     <= 1'b0;
         reverse_cmd <= 1'b0;
      end else begin
         p1_reg      <= i1;
         p2_reg      <= i2;
         run_cmd     <= run_next;
         reverse_cmd <= rev_next;
      end
   end
   assign run_rev_reg = {run_cmd, reverse_cmd};

   // ---------------- up/down ramp, inputs 4 up and 5 down ----------------
   logic [15:0] rtick_cnt_reg;
   wire rtick = rtick_cnt_reg == 16'(RAMP_TICK_CYCLES - 1);
   // per millisecond, a rate in mHz/s is the same figure in micro-Hz
   wire [31:0] step = (res_reg == 2'h1) ? 32'(rate_reg) * 32'h0000000A
                                        : 32'(rate_reg);          // [R5] [R6]
   wire [32:0] up_sum = {1'b0, freq_ref_uhz} + {1'b0, step};
   always_ff @(posedge aclk) begin
      if (!aresetn || rtick) rtick_cnt_reg <= 16'h0000;
      else rtick_cnt_reg <= rtick_cnt_reg + 16'h0001;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) freq_ref_uhz <= 32'h00000000;
      else if (rtick && input_active[3] && !input_active[4])
         freq_ref_uhz <= up_sum[32] ? 32'hFFFFFFFF : up_sum[31:0]; // [R5]
      else if (rtick && input_active[4] && !input_active[3])
         freq_ref_uhz <= (freq_ref_uhz > step) ? freq_ref_uhz - step : 32'h00000000;
   end

   // ---------------- output functions ----------------
   logic [15:0] fvec;
   assign fvec = {6'h00,
                  at_lower_lim | ~drive_running,                  // [R22]
                  at_lower_lim & drive_running,                   // [R21]
                  at_upper_lim,                                   // [R20]
                  speed_ctrl & torque_lim,                        // [R19]
                  set_beyond_lim & (at_upper_lim | at_lower_lim), // [R18]
                  drive_fault & ~drive_undervolt,                 // [R17]
                  drive_fault,                                    // [R17]
                  drive_running,                                  // [R16]
                  drive_ready & ~drive_fault,                     // [R15]
                  1'b0};                                          // [R15]

   logic [8:0] fout_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) fout_reg <= 9'h000;
      else for (int k = 0; k < 9; k++) fout_reg[k] <= fvec[func_reg[k]];   // [R14]
   end

   // ---------------- pulse generator ----------------
   logic [26:0] pacc_reg;
   logic        pulse_reg, fm_reg;
   logic [8:0]  gap_reg;
   wire  [15:0] pf = (pfreq_reg > 16'(`DTI_PULSE_MAX_HZ)) ? 16'(`DTI_PULSE_MAX_HZ)
                                                        : pfreq_reg;  // [R13]
   wire  [26:0] psum = pacc_reg + 27'({pf, 1'b0});
   wire         ptog = psum >= 27'(`DTI_CLK_HZ);
   always_ff @(posedge aclk) begin
      if (!aresetn || mux_mode_reg) begin
         pacc_reg  <= 27'h0000000;
         pulse_reg <= 1'b0;
      end else if (ptog) begin
         pacc_reg  <= psum - 27'(`DTI_CLK_HZ);
         pulse_reg <= ~pulse_reg;
      end else begin
         pacc_reg  <= psum;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) fm_reg <= 1'b0;
      else fm_reg <= mux_mode_reg ? fout_reg[0] : pulse_reg;       // [R12]
   end
   assign term_out = {fout_reg[8:1], fm_reg};

   // ---------------- checks ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) gap_reg <= 9'h000;
      else if (!mux_mode_reg && ptog) gap_reg <= 9'h000;
      else if (gap_reg != 9'h1FF) gap_reg <= gap_reg + 9'h001;
   end

   property p_enable_stop;
      @(posedge aclk) disable iff (!aresetn)
      (cmd_mode_reg == 2'h3 && !i3) |=> !run_cmd;
   endproperty
   a_enable_stop: assert property (p_enable_stop) else $error("run kept without enable"); // [R3]

   property p_run_press;
      @(posedge aclk) disable iff (!aresetn)
      (cmd_mode_reg == 2'h3 && i3 && i1 && !p1_reg) |=> run_cmd;
   endproperty
   a_run_press: assert property (p_run_press) else $error("run press ignored"); // [R4]

   property p_direction;
      @(posedge aclk) disable iff (!aresetn)
      (cmd_mode_reg == 2'h3) |=> (reverse_cmd == $past(i2));
   endproperty
   a_direction: assert property (p_direction) else $error("direction wrong"); // [R2]

   property p_pulse_limit;
      @(posedge aclk) disable iff (!aresetn)
      $changed(pulse_reg) && !mux_mode_reg |-> $past(gap_reg) >= 9'(`DTI_PULSE_MIN_GAP);
   endproperty
   a_pulse_limit: assert property (p_pulse_limit) else $error("pulse too fast"); // [R13]

   property p_mux_pulse;
      @(posedge aclk) disable iff (!aresetn)
      !mux_mode_reg ##1 !mux_mode_reg |-> term_out[0] == $past(pulse_reg);
   endproperty
   a_mux_pulse: assert property (p_mux_pulse) else $error("mux terminal wrong"); // [R12]

   property p_func_none;
      @(posedge aclk) disable iff (!aresetn)
      (func_reg[1] == 4'h0) [*2] |-> !term_out[1];
   endproperty
   a_func_none: assert property (p_func_none) else $error("function 0 active"); // [R15]

   property p_lower_stop;
      @(posedge aclk) disable iff (!aresetn)
      (func_reg[1] == 4'h8 && !drive_running) |=> !term_out[1];
   endproperty
   a_lower_stop: assert property (p_lower_stop) else $error("function 8 on at stop"); // [R21]

   property p_nodelay;
      @(posedge aclk) disable iff (!aresetn)
      aresetn |=> input_active[9:5] == $past(pc[9:5]);
   endproperty
   a_nodelay: assert property (p_nodelay) else $error("upper input delayed"); // [R8]

   property p_ramp_up;
      @(posedge aclk) disable iff (!aresetn)
      (rtick && input_active[3] && !input_active[4] && !up_sum[32])
         |=> freq_ref_uhz == $past(up_sum[31:0]);
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("ramp step wrong"); // [R5]
endmodule // dti_top
`default_nettype wire

// ---- rtl/dti_map.svh ----
`ifndef DTI_MAP_SVH
`define DTI_MAP_SVH
// register byte addresses
`define DTI_ADDR_CMD_MODE   8'h00
`define DTI_ADDR_UPDN_RATE  8'h04
`define DTI_ADDR_FREQ_RES   8'h08
`define DTI_ADDR_POL_LOW    8'h0C
`define DTI_ADDR_POL_HIGH   8'h10
`define DTI_ADDR_MUX_MODE   8'h14
`define DTI_ADDR_PULSE_FREQ 8'h18
`define DTI_ADDR_STATUS     8'h1C
`define DTI_ADDR_FREQ_REF   8'h20
`define DTI_ADDR_OUT_FUNC   8'h40
`define DTI_ADDR_DELAY      8'h80
// field positions
`define DTI_STAT_RUN        11
`define DTI_STAT_REV        10
// reset values
`define DTI_RST_CMD_MODE    2'h0
`define DTI_RST_UPDN_RATE   16'h03E8
`define DTI_RST_FREQ_RES    2'h2
`define DTI_RST_POL         20'h00000
`define DTI_RST_MUX_MODE    1'h1
`define DTI_RST_OUT_FUNC    36'h000001230
`define DTI_RST_DELAY       15'h0000
`define DTI_RST_PULSE_FREQ  16'h0000
// timing
`define DTI_CLK_HZ          40000000
`define DTI_CLK_NS          25
`define DTI_DELAY_TICK_NS   100000000
`define DTI_RAMP_TICK_NS    1000000
`define DTI_PULSE_MAX_HZ    50000
`define DTI_PULSE_MIN_GAP   (`DTI_CLK_HZ / (2 * `DTI_PULSE_MAX_HZ) - 1)
`endif

// ---- rtl/dti_pkg.sv ----
package dti_pkg;
   typedef enum logic [1:0] {
      DTI_TWO_LINE_1   = 2'b00,
      DTI_TWO_LINE_2   = 2'b01,
      DTI_THREE_LINE_1 = 2'b10,
      DTI_THREE_LINE_2 = 2'b11
   } dti_cmd_mode_t;
   typedef enum logic [3:0] {
      DTI_F_NONE     = 4'h0,
      DTI_F_READY    = 4'h1,
      DTI_F_RUNNING  = 4'h2,
      DTI_F_FAULT    = 4'h3,
      DTI_F_FAULT_UV = 4'h4,
      DTI_F_SWING    = 4'h5,
      DTI_F_TORQUE   = 4'h6,
      DTI_F_UPPER    = 4'h7,
      DTI_F_LOWER    = 4'h8,
      DTI_F_LOWER_ST = 4'h9
   } dti_out_func_t;
endpackage

// ---- verification/dti_sw_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module dti_sw_bank (
   input  wire logic       aclk,    // bench clock
   input  wire logic [9:0] closed,  // 1 = contact shut
   output logic      [9:0] term_in  // terminal levels
);
   // contacts reach the terminals one clock later, without bounce; bench opens the enable while running to check the stop
   always_ff @(posedge aclk) term_in <= closed;
endmodule // dti_sw_bank
`default_nettype wire

// ---- verification/tb_dti_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_dti_top;
   logic        aclk = 0, aresetn = 0, p;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, freq_ref_uhz, d, f1;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, run_cmd, reverse_cmd;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [8:0]  st = 0, term_out;
   logic [9:0]  closed = 0, term_in, input_active;
   int          n_fail = 0, check_count = 0, cyc = 0, n;
   wire logic   drive_ready, drive_fault, drive_undervolt, drive_running, set_beyond_lim;
   wire logic   at_upper_lim, at_lower_lim, speed_ctrl, torque_lim;
   logic [7:0]  ra [9] = '{8'h04, 8'h08, 8'h14, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h0C};
   logic [31:0] rv [9] = '{1000, 2, 1, 0, 3, 2, 1, 0, 0};
   logic [8:0]  pat [4] = '{9'h006, 9'h1D9, 9'h0A2, 9'h141};
   assign {torque_lim, speed_ctrl, at_lower_lim, at_upper_lim, set_beyond_lim,
           drive_running, drive_undervolt, drive_fault, drive_ready} = st;
   always #12.5 aclk = ~aclk;
   dti_sw_bank SW (.aclk, .closed, .term_in);
   dti_top #(.DELAY_TICK_CYCLES(10), .RAMP_TICK_CYCLES(8)) DUT (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .term_in, .drive_ready, .drive_fault,
      .drive_undervolt, .drive_running, .set_beyond_lim, .at_upper_lim, .at_lower_lim,
      .speed_ctrl, .torque_lim, .input_active, .run_cmd, .reverse_cmd, .freq_ref_uhz,
      .term_out);
   task automatic w(input int c);
      repeat (c) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp; s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic fx(input int f, input logic [8:0] s);
      case (f)
         0: return 1'b0;
         1: return s[0] & !s[1];
         2: return s[3];
         3: return s[1];
         4: return s[1] & !s[2];
         5: return s[4] & (s[5] | s[6]);
         6: return s[7] & s[8];
         7: return s[5];
         8: return s[6] & s[3];
         default: return s[6] | !s[3];
      endcase
   endfunction
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      w(6);
      aresetn <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i]);
         chk("reset", rv[i], d);
      end
      rd(8'h3C); chk("bad rd", 2, r);
      wr(8'h3C, 7); chk("bad wr", 2, r);
      w(10); chk("open", 10'h3FF, input_active);
      wr(8'h0C, 32'h11111); wr(8'h10, 32'h11111);
      closed <= 10'h020;
      w(10); chk("tied", 10'h020, input_active);
      wr(8'h00, 3); closed <= 10'h001;
      w(4); closed <= 0;
      w(8); chk("run off", 0, run_cmd);
      closed <= 10'h004; w(8); closed <= 10'h005;
      w(4); closed <= 10'h004;
      w(8); chk("run", 3'b100, {run_cmd, reverse_cmd, input_active[0]});
      rd(8'h1C); chk("status", 32'h00000804, d);
      closed <= 10'h006; w(8); chk("rev", 1, reverse_cmd);
      closed <= 0; w(8); chk("stop", 0, run_cmd);
      st <= pat[1]; w(3); chk("outs", 9'h00C, term_out);
      for (int f = 0; f < 10; f++) begin
         wr(8'h44, f);
         foreach (pat[i]) begin
            st <= pat[i]; w(3);
            chk("func", fx(f, pat[i]), term_out[1]);
         end
      end
      st <= pat[1]; wr(8'h40, 2); w(3); chk("mux sw", 1, term_out[0]);
      wr(8'h14, 0); w(3); chk("mux pulse", 0, term_out[0]);
      wr(8'h18, 32'hFFFF); n = 0; p = term_out[0];
      repeat (4000) begin
         @(posedge aclk);
         if (term_out[0] !== p) n++;
         p = term_out[0];
      end
      chk("toggles", 1, n >= 9 && n <= 10);
      wr(8'h80, 3); wr(8'h84, 5); closed <= 10'h021;
      w(15); chk("on early", 2'b10, {input_active[5], input_active[0]});
      w(30); chk("on", 1, input_active[0]);
      closed <= 10'h020; w(20); closed <= 10'h021;
      w(60); chk("restart", 1, input_active[0]);
      closed <= 10'h020; w(65); chk("off", 0, input_active[0]);
      closed <= 10'h028; w(80); closed <= 10'h020; w(10); f1 = freq_ref_uhz;
      chk("ramp", 1, f1 % 1000 == 0 && f1 >= 9000 && f1 <= 11000);
      wr(8'h08, 1); closed <= 10'h028; w(80); closed <= 10'h020; w(10);
      d = freq_ref_uhz - f1;
      chk("ramp x10", 1, d % 10000 == 0 && d >= 90000 && d <= 110000);
      test_done;
   end
endmodule // tb_dti_top
`default_nettype wire
